// ==== inc/port_ef_map.svh ====
// register offsets, field positions, reset values and codes for the port e/f block
`ifndef PORT_EF_MAP_SVH
`define PORT_EF_MAP_SVH

`define PEF_OFF_E_PIN      8'h00
`define PEF_OFF_E_LAT      8'h04
`define PEF_OFF_E_DIR      8'h08
`define PEF_OFF_A_LAT      8'h0C
`define PEF_OFF_F_PIN      8'h10
`define PEF_OFF_F_LAT      8'h14
`define PEF_OFF_F_DIR      8'h18
`define PEF_OFF_ANALOG     8'h1C

`define PEF_RST_LAT        8'h00
`define PEF_RST_DIR        8'hFF
`define PEF_RST_A_LAT      8'h00
`define PEF_RST_ANALOG     2'h0

`define PEF_BIT_E_PULLUP   6
`define PEF_BIT_D_PULLUP   7
`define PEF_BIT_CMP_OFF    0
`define PEF_BIT_DIGITAL    1

`define PEF_E_MASK_SMALL   8'h3F
`define PEF_E_MASK_FULL    8'hFF
`define PEF_F_MASK_SMALL   8'hFE
`define PEF_F_MASK_FULL    8'hFF
`define PEF_F_CMP_PINS     8'h7E
`define PEF_F_RF0          8'h01

`define PEF_STRAP_SMALL    2'h0
`define PEF_STRAP_MID      2'h1

`endif

// ==== inc/port_ef_pkg.sv ====
// types shared by the port e/f pin control block
package port_ef_pkg;

  typedef enum logic [1:0] {
    pkg_small,
    pkg_mid,
    pkg_large
  } pkg_size_e;

  typedef enum logic [3:0] {
    sel_e_pin,
    sel_e_lat,
    sel_e_dir,
    sel_a_lat,
    sel_f_pin,
    sel_f_lat,
    sel_f_dir,
    sel_analog,
    sel_none
  } reg_sel_e;

  typedef logic [7:0] port_byte_t;

endpackage : port_ef_pkg

// ==== design/port_f_pin_mux.sv ====
// next-value logic for the port f pin drivers
`timescale 1ns/100ps
module port_f_pin_mux (
  // register state
  input wire port_ef_pkg::port_byte_t lat,
  input wire port_ef_pkg::port_byte_t dir,
  input wire port_ef_pkg::port_byte_t width_mask,
  input wire logic comparators_on,
  // comparator outputs
  input wire logic comp1_out,
  input wire logic comp2_out,
  input wire logic [1:0] comp_out_en,
  // pin next values
  output port_ef_pkg::port_byte_t out_nxt,
  output port_ef_pkg::port_byte_t oe_nxt
);
  import port_ef_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      logic cmp_own;
      // comparator 2 drives pin 1, comparator 1 drives pin 2
      if (i == 1) begin : g_c2
        assign cmp_own = comparators_on & comp_out_en[1];
        assign out_nxt[i] = cmp_own ? comp2_out : lat[i];
      end else if (i == 2) begin : g_c1
        assign cmp_own = comparators_on & comp_out_en[0];
        assign out_nxt[i] = cmp_own ? comp1_out : lat[i];
      end else begin : g_plain
        assign cmp_own = 1'b0;
        assign out_nxt[i] = lat[i] & ~cmp_own;
      end
      // direction 1 floats the driver, unimplemented pins never drive
      assign oe_nxt[i] = ~dir[i] & width_mask[i];
    end
  endgenerate

endmodule : port_f_pin_mux

// ==== design/port_e_upper_mux.sv ====
// next-value logic for the port e pin drivers and pull-ups
`timescale 1ns/100ps
module port_e_upper_mux (
  // register state
  input wire port_ef_pkg::port_byte_t lat,
  input wire port_ef_pkg::port_byte_t dir,
  input wire port_ef_pkg::port_byte_t width_mask,
  input wire port_ef_pkg::pkg_size_e pkg,
  input wire logic pullup_en,
  // configuration
  input wire logic pwm_pin_map_select,
  input wire logic capture2_pin_map_select,
  input wire logic mcu_mode,
  // external memory bus, bits 13 to 15
  input wire logic ext_bus_active,
  input wire logic [2:0] ext_bus_ad_out,
  input wire logic [2:0] ext_bus_ad_oe,
  // pwm and compare sources
  input wire logic pwm1_channel_b,
  input wire logic pwm1_channel_c,
  input wire logic pwm1_tristate,
  input wire logic capture_compare_2_out,
  input wire logic pwm2_tristate,
  // pin next values
  output port_ef_pkg::port_byte_t out_nxt,
  output port_ef_pkg::port_byte_t oe_nxt,
  output port_ef_pkg::port_byte_t pu_nxt
);
  import port_ef_pkg::*;

  logic bus_own;
  logic pwm_map;
  logic ccp_map;
  port_byte_t alt_own;
  port_byte_t alt_val;
  port_byte_t alt_tri;

  assign bus_own = ext_bus_active & (pkg == pkg_large);
  assign pwm_map = pwm_pin_map_select & (pkg != pkg_small);
  assign ccp_map = ~capture2_pin_map_select & mcu_mode & (pkg != pkg_small);

  always_comb begin
    alt_own = 8'h00;
    alt_val = 8'h00;
    alt_tri = 8'h00;
    if (pwm_map) begin
      alt_own[5] = 1'b1;
      alt_val[5] = pwm1_channel_c;
      alt_tri[5] = pwm1_tristate;
      alt_own[6] = 1'b1;
      alt_val[6] = pwm1_channel_b;
      alt_tri[6] = pwm1_tristate;
    end
    if (ccp_map) begin
      alt_own[7] = 1'b1;
      alt_val[7] = capture_compare_2_out;
      alt_tri[7] = pwm2_tristate;
    end
  end

  always_comb begin
    out_nxt = 8'h00;
    oe_nxt = 8'h00;
    pu_nxt = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (!width_mask[i]) begin
        out_nxt[i] = 1'b0;
      end else if (i >= 5 && bus_own) begin
        // bus ignores the direction bits
        out_nxt[i] = ext_bus_ad_out[i-5];
        oe_nxt[i] = ext_bus_ad_oe[i-5];
      end else if (!dir[i]) begin
        out_nxt[i] = alt_own[i] ? alt_val[i] : lat[i];
        oe_nxt[i] = ~(alt_own[i] & alt_tri[i]);
      end else begin
        pu_nxt[i] = pullup_en;
      end
    end
  end

endmodule : port_e_upper_mux

// ==== design/port_e_f_pin_control.sv ====
// apb register file and pin control for port e (upper pins) and port f
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
`include "port_ef_map.svh"
module port_e_f_pin_control (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device configuration
  input wire logic [1:0] pkg_size_strap,
  input wire logic pwm_pin_map_select,
  input wire logic capture2_pin_map_select,
  input wire logic mcu_mode,
  // port e pins
  input wire port_ef_pkg::port_byte_t pe_in,
  output port_ef_pkg::port_byte_t pe_out,
  output port_ef_pkg::port_byte_t pe_oe,
  output port_ef_pkg::port_byte_t pe_pullup,
  // external memory bus, bits 13 to 15
  input wire logic ext_bus_active,
  input wire logic [2:0] ext_bus_ad_out,
  input wire logic [2:0] ext_bus_ad_oe,
  output logic [2:0] ext_bus_ad_in,
  // pwm and capture/compare
  input wire logic pwm1_channel_b,
  input wire logic pwm1_channel_c,
  input wire logic pwm1_tristate,
  input wire logic capture_compare_2_out,
  input wire logic pwm2_tristate,
  output logic capture_compare_2_in,
  // port f pins
  input wire port_ef_pkg::port_byte_t pf_in,
  output port_ef_pkg::port_byte_t pf_out,
  output port_ef_pkg::port_byte_t pf_oe,
  output port_ef_pkg::port_byte_t pf_analog,
  // comparator outputs
  input wire logic comp1_out,
  input wire logic comp2_out,
  input wire logic [1:0] comp_out_en,
  // port d pull-up control
  output logic port_d_pullup_enable
);
  import port_ef_pkg::*;

  // address decode, shared by read and write paths
  function automatic reg_sel_e decode_addr(input logic [7:0] addr);
    reg_sel_e sel;
    sel = sel_none;
    if (addr == `PEF_OFF_E_PIN) begin
      sel = sel_e_pin;
    end else if (addr == `PEF_OFF_E_LAT) begin
      sel = sel_e_lat;
    end else if (addr == `PEF_OFF_E_DIR) begin
      sel = sel_e_dir;
    end else if (addr == `PEF_OFF_A_LAT) begin
      sel = sel_a_lat;
    end else if (addr == `PEF_OFF_F_PIN) begin
      sel = sel_f_pin;
    end else if (addr == `PEF_OFF_F_LAT) begin
      sel = sel_f_lat;
    end else if (addr == `PEF_OFF_F_DIR) begin
      sel = sel_f_dir;
    end else if (addr == `PEF_OFF_ANALOG) begin
      sel = sel_analog;
    end
    return sel;
  endfunction : decode_addr

  function automatic port_byte_t e_width(input pkg_size_e p);
    return (p == pkg_small) ? `PEF_E_MASK_SMALL : `PEF_E_MASK_FULL;
  endfunction : e_width

  function automatic port_byte_t f_width(input pkg_size_e p);
    return (p == pkg_large) ? `PEF_F_MASK_FULL : `PEF_F_MASK_SMALL;
  endfunction : f_width

  // package strap
  pkg_size_e pkg_r;
  logic strap_done_r;

  // registers
  port_byte_t e_lat_r;
  port_byte_t e_dir_r;
  port_byte_t a_lat_r;
  port_byte_t f_lat_r;
  port_byte_t f_dir_r;
  logic [1:0] analog_r;

  // pin samples
  port_byte_t pe_in_r;
  port_byte_t pf_in_r;

  // bus state
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // pin output flops
  port_byte_t pe_out_r;
  port_byte_t pe_oe_r;
  port_byte_t pe_pullup_r;
  port_byte_t pf_out_r;
  port_byte_t pf_oe_r;
  port_byte_t pf_analog_r;
  logic [2:0] ext_bus_ad_in_r;
  logic capture_compare_2_in_r;

  reg_sel_e sel;
  logic setup_go;
  logic write_go;
  port_byte_t e_mask;
  port_byte_t f_mask;
  port_byte_t f_digital;
  port_byte_t wbyte;
  logic comparators_on;
  logic [31:0] prdata_nxt;
  port_byte_t pe_out_nxt;
  port_byte_t pe_oe_nxt;
  port_byte_t pe_pu_nxt;
  port_byte_t pf_out_nxt;
  port_byte_t pf_oe_nxt;

  assign sel = decode_addr(paddr);
  assign setup_go = psel & ~penable & ~pready_r;
  assign write_go = psel & penable & pready_r & pwrite;
  assign wbyte = pwdata[7:0];
  assign e_mask = e_width(pkg_r);
  assign f_mask = f_width(pkg_r);
  assign comparators_on = ~analog_r[`PEF_BIT_CMP_OFF];

  // digital input path per port f pin
  always_comb begin
    f_digital = f_mask;
    if (!analog_r[`PEF_BIT_DIGITAL]) begin
      f_digital = f_digital & ~(`PEF_F_CMP_PINS | `PEF_F_RF0);
    end
    if (comparators_on) begin
      f_digital = f_digital & ~`PEF_F_CMP_PINS;
    end
  end

  // strap caught once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkg_r <= pkg_small;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      if (pkg_size_strap == `PEF_STRAP_SMALL) begin
        pkg_r <= pkg_small;
      end else if (pkg_size_strap == `PEF_STRAP_MID) begin
        pkg_r <= pkg_mid;
      end else begin
        pkg_r <= pkg_large;
      end
    end
  end

  // port e latch and direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_lat_r <= `PEF_RST_LAT;
      e_dir_r <= `PEF_RST_DIR;
    end else if (write_go) begin
      if (sel == sel_e_pin || sel == sel_e_lat) begin
        e_lat_r <= wbyte & e_mask;
      end else if (sel == sel_e_dir) begin
        e_dir_r <= wbyte & e_mask;
      end
    end
  end

  // port a latch carries both pull-up enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_lat_r <= `PEF_RST_A_LAT;
    end else if (write_go && sel == sel_a_lat) begin
      a_lat_r <= wbyte;
    end
  end

  // port f latch, direction and analog control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_lat_r <= `PEF_RST_LAT;
      f_dir_r <= `PEF_RST_DIR;
      analog_r <= `PEF_RST_ANALOG;
    end else if (write_go) begin
      if (sel == sel_f_pin || sel == sel_f_lat) begin
        f_lat_r <= wbyte & f_mask;
      end else if (sel == sel_f_dir) begin
        f_dir_r <= wbyte & f_mask;
      end else if (sel == sel_analog) begin
        analog_r <= wbyte[1:0];
      end
    end
  end

  // pin samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe_in_r <= 8'h00;
      pf_in_r <= 8'h00;
    end else begin
      pe_in_r <= pe_in;
      pf_in_r <= pf_in;
    end
  end

  // read mux
  always_comb begin
    prdata_nxt = 32'h00000000;
    if (sel == sel_e_pin) begin
      prdata_nxt[7:0] = pe_in_r & e_mask;
    end else if (sel == sel_e_lat) begin
      prdata_nxt[7:0] = e_lat_r & e_mask;
    end else if (sel == sel_e_dir) begin
      prdata_nxt[7:0] = e_dir_r & e_mask;
    end else if (sel == sel_a_lat) begin
      prdata_nxt[7:0] = a_lat_r;
    end else if (sel == sel_f_pin) begin
      prdata_nxt[7:0] = pf_in_r & f_digital;
    end else if (sel == sel_f_lat) begin
      prdata_nxt[7:0] = f_lat_r & f_mask;
    end else if (sel == sel_f_dir) begin
      prdata_nxt[7:0] = f_dir_r & f_mask;
    end else if (sel == sel_analog) begin
      prdata_nxt[1:0] = analog_r;
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setup_go) begin
      pready_r <= 1'b1;
      prdata_r <= pwrite ? 32'h00000000 : prdata_nxt;
      pslverr_r <= (sel == sel_none);
    end else begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
  end

  port_e_upper_mux u_port_e_mux (
    .lat(e_lat_r),
    .dir(e_dir_r),
    .width_mask(e_mask),
    .pkg(pkg_r),
    .pullup_en(a_lat_r[`PEF_BIT_E_PULLUP]),
    .pwm_pin_map_select(pwm_pin_map_select),
    .capture2_pin_map_select(capture2_pin_map_select),
    .mcu_mode(mcu_mode),
    .ext_bus_active(ext_bus_active),
    .ext_bus_ad_out(ext_bus_ad_out),
    .ext_bus_ad_oe(ext_bus_ad_oe),
    .pwm1_channel_b(pwm1_channel_b),
    .pwm1_channel_c(pwm1_channel_c),
    .pwm1_tristate(pwm1_tristate),
    .capture_compare_2_out(capture_compare_2_out),
    .pwm2_tristate(pwm2_tristate),
    .out_nxt(pe_out_nxt),
    .oe_nxt(pe_oe_nxt),
    .pu_nxt(pe_pu_nxt)
  );

  port_f_pin_mux u_port_f_mux (
    .lat(f_lat_r),
    .dir(f_dir_r),
    .width_mask(f_mask),
    .comparators_on(comparators_on),
    .comp1_out(comp1_out),
    .comp2_out(comp2_out),
    .comp_out_en(comp_out_en),
    .out_nxt(pf_out_nxt),
    .oe_nxt(pf_oe_nxt)
  );

  // registered pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe_out_r <= 8'h00;
      pe_oe_r <= 8'h00;
      pe_pullup_r <= 8'h00;
      pf_out_r <= 8'h00;
      pf_oe_r <= 8'h00;
      pf_analog_r <= `PEF_F_CMP_PINS;
    end else begin
      pe_out_r <= pe_out_nxt;
      pe_oe_r <= pe_oe_nxt;
      pe_pullup_r <= pe_pu_nxt;
      pf_out_r <= pf_out_nxt;
      pf_oe_r <= pf_oe_nxt;
      pf_analog_r <= f_mask & ~f_digital & ~8'h80;
    end
  end

  // inputs handed to the alternate functions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_bus_ad_in_r <= 3'h0;
      capture_compare_2_in_r <= 1'b0;
    end else begin
      ext_bus_ad_in_r <= pe_in_r[7:5];
      capture_compare_2_in_r <= pe_in_r[7] & e_dir_r[7];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pe_out = pe_out_r;
  assign pe_oe = pe_oe_r;
  assign pe_pullup = pe_pullup_r;
  assign pf_out = pf_out_r;
  assign pf_oe = pf_oe_r;
  assign pf_analog = pf_analog_r;
  assign ext_bus_ad_in = ext_bus_ad_in_r;
  assign capture_compare_2_in = capture_compare_2_in_r;
  assign port_d_pullup_enable = a_lat_r[`PEF_BIT_D_PULLUP];

endmodule : port_e_f_pin_control

// ==== testbench/port_ef_monitor.sv ====
// assertions and covers on the port e/f pin control ports
`timescale 1ns/100ps
`include "port_ef_map.svh"
module port_ef_monitor (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // configuration
  input wire logic [1:0] pkg_size_strap,
  input wire logic pwm_pin_map_select,
  input wire logic pwm1_tristate,
  input wire logic ext_bus_active,
  input wire logic [2:0] ext_bus_ad_out,
  input wire logic [2:0] ext_bus_ad_oe,
  // pins
  input wire port_ef_pkg::port_byte_t pe_in,
  input wire port_ef_pkg::port_byte_t pe_out,
  input wire port_ef_pkg::port_byte_t pe_oe,
  input wire logic [2:0] ext_bus_ad_in,
  input wire logic capture_compare_2_in,
  input wire logic port_d_pullup_enable
);
  import port_ef_pkg::*;
  logic [1:0] up_r;
  logic [2:0] pe_hi;
  logic wr_pa;
  // cycles since reset release, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  assign pe_hi = pe_in[7:5];
  assign wr_pa = psel && penable && pready && pwrite && (paddr == `PEF_OFF_A_LAT);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  data_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  err_unmapped_a: assert property (pready && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > `PEF_OFF_ANALOG))
    else $error("error flag wrong for address");
  bus_owns_pins_a: assert property ((ext_bus_active && pkg_size_strap[1]) [*3] |=>
    pe_oe[7:5] == $past(ext_bus_ad_oe) &&
    ((pe_out[7:5] ^ $past(ext_bus_ad_out)) & pe_oe[7:5]) == 3'h0)
    else $error("bus does not own upper pins");
  bus_in_delay_a: assert property (up_r == 2'h3 |->
    ext_bus_ad_in == $past(pe_hi, 2))
    else $error("bus input not two cycles late");
  cc2_in_gated_a: assert property (up_r == 2'h3 && $past(pe_hi, 2) < 3'h4 |->
    !capture_compare_2_in)
    else $error("capture input high without pin");
  pwm_tristate_a: assert property ((pwm_pin_map_select && pwm1_tristate &&
    !ext_bus_active && pkg_size_strap != 2'h0) [*2] |=> pe_oe[6:5] == 2'h0)
    else $error("pwm pins driven in shutdown");
  pullup_d_write_a: assert property ($changed(port_d_pullup_enable) |->
    $past(wr_pa) || $past(wr_pa, 2))
    else $error("port d pull-up changed without write");
  cover property (wr_pa);
  cover property (pready && pslverr);
  cover property (ext_bus_active && pkg_size_strap[1]);
endmodule : port_ef_monitor

bind port_e_f_pin_control port_ef_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .pkg_size_strap, .pwm_pin_map_select, .pwm1_tristate,
  .ext_bus_active, .ext_bus_ad_out, .ext_bus_ad_oe, .pe_in, .pe_out, .pe_oe, .ext_bus_ad_in,
  .capture_compare_2_in, .port_d_pullup_enable);

// ==== testbench/port_e_f_pin_control_tb_top.sv ====
// self-checking bench for the port e/f pin control block
`timescale 1ns/100ps
`include "port_ef_map.svh"
module port_e_f_pin_control_tb_top;
  import port_ef_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h34;
  logic pready, pslverr, ext_bus_active = 1'b0, capture_compare_2_in, port_d_pullup_enable;
  logic [1:0] pkg_size_strap = 2'h0, comp_out_en = 2'h0;
  logic pwm_pin_map_select = 1'b0, capture2_pin_map_select = 1'b1, mcu_mode = 1'b0;
  logic pwm1_channel_b = 1'b0, pwm1_channel_c = 1'b0, pwm1_tristate = 1'b0;
  logic capture_compare_2_out = 1'b0, pwm2_tristate = 1'b0, comp1_out = 1'b0, comp2_out = 1'b0;
  logic [2:0] ext_bus_ad_out = 3'h0, ext_bus_ad_oe = 3'h0, ext_bus_ad_in;
  port_byte_t pe_in = 8'h00, pf_in = 8'hFF, pe_out, pe_oe, pe_pullup, pf_out, pf_oe, pf_analog;
  port_byte_t d, l, p;
  logic [33:0] expq [$];
  logic [33:0] note;
  int errors = 0, checked = 0;

  port_e_f_pin_control i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pkg_size_strap, .pwm_pin_map_select, .capture2_pin_map_select, .mcu_mode, .pe_in,
    .pe_out, .pe_oe, .pe_pullup, .ext_bus_active, .ext_bus_ad_out, .ext_bus_ad_oe,
    .ext_bus_ad_in, .pwm1_channel_b, .pwm1_channel_c, .pwm1_tristate, .capture_compare_2_out,
    .pwm2_tristate, .capture_compare_2_in, .pf_in, .pf_out, .pf_oe, .pf_analog, .comp1_out,
    .comp2_out, .comp_out_en, .port_d_pullup_enable
  );

  always #4 pclk = ~pclk;

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] dat,
    input logic [7:0] e, input logic err);
    int n;
    expq.push_back({~w, err, 24'h0, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {rnd(), rnd(), rnd(), dat};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      check("pready", 32'h0, 32'h1);
      close_out();
    end else begin
      penable <= 1'b0;
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    xfer(1'b1, a, dat, 8'h00, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, e, 1'b0);
  endtask : rd

  task automatic tick(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : tick

  task automatic do_reset(input logic [1:0] s);
    psel <= 1'b0;
    presetn <= 1'b0;
    pkg_size_strap <= s;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset

  // answer checker: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (expq.size() == 0) begin
        check("queue", 32'h0, 32'h1);
      end else begin
        note = expq.pop_front();
        check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
        if (note[33]) begin
          check("prdata", prdata, note[31:0]);
        end
      end
    end
  end

  initial begin
    do_reset(2'h0);
    check("pf_analog", pf_analog, 8'h7E);
    rd(`PEF_OFF_E_DIR, 8'h3F);
    rd(`PEF_OFF_F_DIR, 8'hFE);
    rd(`PEF_OFF_F_PIN, 8'h80);
    rd(`PEF_OFF_A_LAT, 8'h00);
    xfer(1'b0, 8'h20, 8'h00, 8'h00, 1'b1);
    xfer(1'b1, 8'h24, 8'hFF, 8'h00, 1'b1);
    wr(`PEF_OFF_E_LAT, 8'hFF);
    wr(`PEF_OFF_E_DIR, 8'h00);
    wr(`PEF_OFF_F_DIR, 8'h00);
    wr(`PEF_OFF_ANALOG, 8'h03);
    rd(`PEF_OFF_E_LAT, 8'h3F);
    tick(3);
    check("pe_oe", pe_oe, 8'h3F);
    check("pf_oe", pf_oe, 8'hFE);
    rd(`PEF_OFF_F_PIN, 8'hFE);
    do_reset(2'h2);
    rd(`PEF_OFF_E_DIR, 8'hFF);
    rd(`PEF_OFF_F_DIR, 8'hFF);
    wr(`PEF_OFF_F_DIR, 8'h00);
    comp_out_en <= 2'h3;
    comp1_out <= 1'b1;
    comp2_out <= 1'b1;
    tick(3);
    check("pf_cmp", pf_out[2:1], 2'h3);
    wr(`PEF_OFF_ANALOG, 8'h03);
    tick(3);
    check("pf_cmp", pf_out[2:1], 2'h0);
    check("pf_analog", pf_analog, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      l = rnd();
      p = rnd();
      pf_in <= p;
      wr(`PEF_OFF_F_DIR, d);
      wr(`PEF_OFF_F_LAT, l);
      tick(3);
      check("pf_oe", pf_oe, port_byte_t'(~d));
      check("pf_drive", pf_out & pf_oe, port_byte_t'(l & ~d));
      rd(`PEF_OFF_F_LAT, l);
      rd(`PEF_OFF_F_PIN, p);
      wr(`PEF_OFF_F_PIN, ~l);
      rd(`PEF_OFF_F_LAT, ~l);
    end
    wr(`PEF_OFF_E_DIR, 8'hFF);
    wr(`PEF_OFF_A_LAT, 8'h80);
    tick(3);
    check("pe_pullup", pe_pullup, 8'h00);
    check("pd_pullup", port_d_pullup_enable, 1'b1);
    wr(`PEF_OFF_A_LAT, 8'h40);
    tick(3);
    check("pe_pullup", pe_pullup, 8'hFF);
    check("pd_pullup", port_d_pullup_enable, 1'b0);
    ext_bus_active <= 1'b1;
    ext_bus_ad_oe <= 3'h5;
    ext_bus_ad_out <= 3'h6;
    pe_in <= rnd();
    tick(4);
    check("pe_oe", pe_oe[7:5], 3'h5);
    check("pe_out", pe_out[7:5], 3'h6);
    check("pe_pullup", pe_pullup[7:5], 3'h0);
    check("ad_in", ext_bus_ad_in, pe_in[7:5]);
    ext_bus_active <= 1'b0;
    wr(`PEF_OFF_E_LAT, 8'h00);
    wr(`PEF_OFF_E_DIR, 8'h00);
    pwm_pin_map_select <= 1'b1;
    pwm1_channel_b <= 1'b1;
    pwm1_channel_c <= 1'b1;
    tick(3);
    check("pe_pwm", pe_out[6:5], 2'h3);
    pwm1_tristate <= 1'b1;
    capture2_pin_map_select <= 1'b0;
    mcu_mode <= 1'b1;
    capture_compare_2_out <= 1'b1;
    tick(3);
    check("pe_oe", pe_oe[7:5], 3'h4);
    check("pe_cc2", pe_out[7], 1'b1);
    pwm2_tristate <= 1'b1;
    tick(3);
    check("pe_oe", pe_oe[7], 1'b0);
    pe_in <= 8'h80;
    wr(`PEF_OFF_E_DIR, 8'h80);
    tick(3);
    check("cc2_in", capture_compare_2_in, 1'b1);
    // mid package: 7-bit port f, maps present, external bus not honoured
    do_reset(2'h1);
    rd(`PEF_OFF_F_DIR, 8'hFE);
    rd(`PEF_OFF_E_DIR, 8'hFF);
    wr(`PEF_OFF_E_DIR, 8'h00);
    pwm1_tristate <= 1'b0;
    pwm2_tristate <= 1'b0;
    ext_bus_active <= 1'b1;
    tick(3);
    check("pe_oe", pe_oe, 8'hFF);
    check("pe_mid", pe_out[7:5], 3'h7);
    tick(2);
    check("queue", expq.size(), 32'h0);
    close_out();
  end
endmodule : port_e_f_pin_control_tb_top
